// ### fss_top.sv
// flux start sequencing and stop behaviour selection of the drive
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module fss_top #(
   parameter int unsigned CYC_PER_MS = fss_pkg::CYC_PER_MS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register port
   input wire logic [fss_pkg::AW-1:0] reg_addr,
   input wire logic [fss_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [fss_pkg::DW-1:0] reg_rdata,
   // start sources
   input wire logic [fss_pkg::NUM_DI-1:0] digital_in,
   input wire logic [fss_pkg::NUM_LS-1:0] logic_sig,
   // feedback from the control loop
   input wire logic flux_ref_reached,
   input wire logic standstill,
   // drive commands
   output logic stage_enable,
   output logic torque_enable,
   output logic run_cw,
   output logic run_acw,
   output logic ramp_stop,
   output logic emergency_stop,
   output logic dc_brake,
   output logic flux_active,
   output logic [fss_pkg::DW-1:0] magnetizing_current,
   output logic [fss_pkg::DW-1:0] brake_current
);
   typedef struct packed {
      logic [fss_pkg::NUM_DI-1:0] di_s1;
      logic [fss_pkg::NUM_DI-1:0] di_s2;
      logic [9:0] cfg;
      logic [13:0] min_ms;
      logic [13:0] max_ms;
      logic [6:0] stop_mode;
      logic [6:0] src_cw;
      logic [6:0] src_acw;
      logic [15:0] flux_cur;
      logic [15:0] brk_cur;
      logic [13:0] brk_ms;
      logic [15:0] rdata;
      fss_pkg::fss_state_t st;
      logic dir_cw;
      logic [3:0] beh;
      logic [fss_pkg::DIV_W-1:0] div;
      logic ms_tick;
      logic [13:0] brk_elapsed;
      logic o_stage;
      logic o_torque;
      logic o_cw;
      logic o_acw;
      logic o_ramp;
      logic o_emer;
      logic o_dcb;
      logic [15:0] o_mag;
      logic [15:0] o_brk;
   } fss_top_t;

   localparam logic [fss_pkg::DIV_W-1:0] DIV_LAST =
      fss_pkg::DIV_W'(CYC_PER_MS - 1);

   function automatic logic src_level(input logic [6:0] code,
         input logic [fss_pkg::NUM_DI-1:0] di,
         input logic [fss_pkg::NUM_LS-1:0] ls);
      logic r;
      r = (code == fss_pkg::SRC_HIGH);
      for (int i = 0; i < fss_pkg::NUM_DI; i++) begin
         if (code == fss_pkg::SRC_DI_BASE + 7'(i)) r = di[i];
      end
      for (int i = 0; i < fss_pkg::NUM_LS; i++) begin
         if (code == fss_pkg::SRC_LS_BASE + 7'(i)) r = ls[i];
      end
      return r;
   endfunction : src_level

   function automatic logic [3:0] tens_digit(input logic [6:0] v);
      return 4'(v / fss_pkg::STOP_TEN);
   endfunction : tens_digit

   function automatic logic [3:0] units_digit(input logic [6:0] v);
      return 4'(v % fss_pkg::STOP_TEN);
   endfunction : units_digit

   function automatic logic digit_ok(input logic [3:0] d);
      return d == fss_pkg::BEH_COAST || d == fss_pkg::BEH_RAMP_OFF ||
         d == fss_pkg::BEH_RAMP_HOLD || d == fss_pkg::BEH_EMER_OFF ||
         d == fss_pkg::BEH_EMER_HOLD || d == fss_pkg::BEH_DC_BRAKE;
   endfunction : digit_ok

   function automatic logic stop_ok(input logic [6:0] v);
      return v <= fss_pkg::STOP_MAX && digit_ok(tens_digit(v)) &&
         digit_ok(units_digit(v));
   endfunction : stop_ok

   // dc brake outside the v/f configuration falls back to coasting
   function automatic logic [3:0] eff_beh(input logic [3:0] d,
         input logic [9:0] cfg);
      if (d == fss_pkg::BEH_DC_BRAKE && cfg != fss_pkg::CFG_VF) begin
         return fss_pkg::BEH_COAST;
      end
      return d;
   endfunction : eff_beh

   fss_top_t q;
   fss_top_t n;
   logic cw;
   logic acw;
   logic one;
   logic both;
   logic stop_req;
   logic flux_start;
   logic restart;
   logic [3:0] sel_beh;

   fss_flux_if fx_if ();

   fss_flux_seq u_flux (
      .clk_sys (clk_sys),
      .reset (reset),
      .fx (fx_if.seq)
   );

   always_comb begin
      n = q;
      n.ms_tick = 1'b0;
      flux_start = 1'b0;
      restart = 1'b0;
      n.di_s1 = digital_in;
      n.di_s2 = q.di_s1;
      cw = src_level(q.src_cw, q.di_s2, logic_sig);
      acw = src_level(q.src_acw, q.di_s2, logic_sig);
      one = cw ^ acw;
      both = cw & acw;
      sel_beh = both ? eff_beh(tens_digit(q.stop_mode), q.cfg) :
         eff_beh(units_digit(q.stop_mode), q.cfg);
      stop_req = !one && (q.st == fss_pkg::ST_FLUX || q.st == fss_pkg::ST_RUN);
      if (q.div == DIV_LAST) begin
         n.div = '0;
         n.ms_tick = 1'b1;
      end else begin
         n.div = q.div + 18'h00001;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            fss_pkg::OFS_CONFIG: begin
               if (reg_wdata[9:0] == fss_pkg::CFG_VF) begin
                  n.cfg = reg_wdata[9:0];
                  n.min_ms = fss_pkg::MIN_DEF_ASYN;
                  n.max_ms = fss_pkg::MAX_DEF_VF;
               end else if (reg_wdata[9:0] == fss_pkg::CFG_ASYN) begin
                  n.cfg = reg_wdata[9:0];
                  n.min_ms = fss_pkg::MIN_DEF_ASYN;
                  n.max_ms = fss_pkg::MAX_DEF_ASYN;
               end else if (reg_wdata[9:0] == fss_pkg::CFG_SYN) begin
                  n.cfg = reg_wdata[9:0];
                  n.min_ms = fss_pkg::MIN_DEF_SYN;
                  n.max_ms = fss_pkg::MAX_DEF_SYN;
               end
            end
            fss_pkg::OFS_MIN_TIME: begin
               if (reg_wdata[15:14] == 2'h0 &&
                     reg_wdata[13:0] <= fss_pkg::T_LIMIT) begin
                  n.min_ms = reg_wdata[13:0];
               end
            end
            fss_pkg::OFS_MAX_TIME: begin
               if (reg_wdata[15:14] == 2'h0 &&
                     reg_wdata[13:0] >= fss_pkg::T_ONE &&
                     reg_wdata[13:0] <= fss_pkg::T_LIMIT) begin
                  n.max_ms = reg_wdata[13:0];
               end
            end
            fss_pkg::OFS_STOP_MODE: begin
               if (reg_wdata[15:7] == 9'h000 && stop_ok(reg_wdata[6:0])) begin
                  n.stop_mode = reg_wdata[6:0];
               end
            end
            fss_pkg::OFS_SRC_CW: n.src_cw = reg_wdata[6:0];
            fss_pkg::OFS_SRC_ACW: n.src_acw = reg_wdata[6:0];
            fss_pkg::OFS_FLUX_CUR: n.flux_cur = reg_wdata;
            fss_pkg::OFS_BRK_CUR: n.brk_cur = reg_wdata;
            fss_pkg::OFS_BRK_TIME: begin
               if (reg_wdata[15:14] == 2'h0 &&
                     reg_wdata[13:0] <= fss_pkg::T_LIMIT) begin
                  n.brk_ms = reg_wdata[13:0];
               end
            end
            default: ;
         endcase
      end
      n.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            fss_pkg::OFS_CONFIG: n.rdata = {6'h00, q.cfg};
            fss_pkg::OFS_MIN_TIME: n.rdata = {2'h0, q.min_ms};
            fss_pkg::OFS_MAX_TIME: n.rdata = {2'h0, q.max_ms};
            fss_pkg::OFS_STOP_MODE: n.rdata = {9'h000, q.stop_mode};
            fss_pkg::OFS_SRC_CW: n.rdata = {9'h000, q.src_cw};
            fss_pkg::OFS_SRC_ACW: n.rdata = {9'h000, q.src_acw};
            fss_pkg::OFS_FLUX_CUR: n.rdata = q.flux_cur;
            fss_pkg::OFS_BRK_CUR: n.rdata = q.brk_cur;
            fss_pkg::OFS_BRK_TIME: n.rdata = {2'h0, q.brk_ms};
            fss_pkg::OFS_STATUS: begin
               n.rdata[fss_pkg::ST_STATE_LSB +: 3] = 3'(q.st);
               n.rdata[fss_pkg::ST_FLUX_BIT] = fx_if.active;
               n.rdata[fss_pkg::ST_CW_BIT] = cw;
               n.rdata[fss_pkg::ST_ACW_BIT] = acw;
               n.rdata[fss_pkg::ST_STILL_BIT] = standstill;
            end
            default: n.rdata = '0;
         endcase
      end
      unique case (q.st)
         fss_pkg::ST_IDLE: begin
            // every start from idle magnetizes first; a start from hold goes straight to run
            if (one) begin
               n.st = fss_pkg::ST_FLUX;
               n.dir_cw = cw;
               flux_start = 1'b1;
               restart = 1'b1;
            end
         end
         fss_pkg::ST_FLUX: begin
            if (one && fx_if.done) n.st = fss_pkg::ST_RUN;
         end
         fss_pkg::ST_RUN: begin
            if (one) n.dir_cw = cw;
         end
         fss_pkg::ST_RAMP: begin
            if (one) begin
               n.st = fss_pkg::ST_RUN;
               n.dir_cw = cw;
            end else if (standstill) begin
               if (q.beh == fss_pkg::BEH_RAMP_HOLD ||
                     q.beh == fss_pkg::BEH_EMER_HOLD) begin
                  n.st = fss_pkg::ST_HOLD;
               end else begin
                  n.st = fss_pkg::ST_IDLE;
               end
            end
         end
         fss_pkg::ST_HOLD: begin
            if (one) begin
               n.st = fss_pkg::ST_RUN;
               n.dir_cw = cw;
            end
         end
         fss_pkg::ST_BRAKE: begin
            if (q.brk_elapsed >= q.brk_ms) begin
               n.st = fss_pkg::ST_IDLE;
            end else if (q.ms_tick) begin
               n.brk_elapsed = q.brk_elapsed + 14'h0001;
            end
         end
         default: n.st = fss_pkg::ST_IDLE;
      endcase
      if (stop_req) begin
         n.beh = sel_beh;
         unique case (sel_beh)
            fss_pkg::BEH_COAST: n.st = fss_pkg::ST_IDLE;
            fss_pkg::BEH_RAMP_OFF, fss_pkg::BEH_RAMP_HOLD,
            fss_pkg::BEH_EMER_OFF, fss_pkg::BEH_EMER_HOLD:
               n.st = fss_pkg::ST_RAMP;
            fss_pkg::BEH_DC_BRAKE: begin
               n.st = fss_pkg::ST_BRAKE;
               n.brk_elapsed = '0;
               restart = 1'b1;
            end
            default: n.st = fss_pkg::ST_IDLE;
         endcase
      end
      if (restart) begin
         n.div = '0;
         n.ms_tick = 1'b0;
      end
      n.o_stage = (n.st != fss_pkg::ST_IDLE);
      n.o_torque = (n.st == fss_pkg::ST_RUN || n.st == fss_pkg::ST_RAMP ||
         n.st == fss_pkg::ST_HOLD);
      n.o_cw = (n.st == fss_pkg::ST_RUN) && n.dir_cw;
      n.o_acw = (n.st == fss_pkg::ST_RUN) && !n.dir_cw;
      n.o_ramp = (n.st == fss_pkg::ST_RAMP);
      n.o_emer = (n.st == fss_pkg::ST_RAMP) &&
         (n.beh == fss_pkg::BEH_EMER_OFF || n.beh == fss_pkg::BEH_EMER_HOLD);
      n.o_dcb = (n.st == fss_pkg::ST_BRAKE);
      n.o_mag = (n.st == fss_pkg::ST_FLUX) ? n.flux_cur : '0;
      n.o_brk = (n.st == fss_pkg::ST_BRAKE) ? n.brk_cur : '0;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.cfg <= fss_pkg::CFG_ASYN;
         q.min_ms <= fss_pkg::MIN_DEF_ASYN;
         q.max_ms <= fss_pkg::MAX_DEF_ASYN;
         q.stop_mode <= fss_pkg::STOP_RST;
         q.src_cw <= fss_pkg::SRC_CW_RST;
         q.src_acw <= fss_pkg::SRC_ACW_RST;
         q.flux_cur <= fss_pkg::FLUX_CUR_RST;
         q.brk_cur <= fss_pkg::BRK_CUR_RST;
         q.brk_ms <= fss_pkg::BRK_TIME_RST;
      end else begin
         q <= n;
      end
   end

   assign fx_if.start = flux_start;
   assign fx_if.abort = stop_req;
   assign fx_if.ref_reached = flux_ref_reached;
   assign fx_if.ms_tick = q.ms_tick;
   assign fx_if.min_ms = q.min_ms;
   assign fx_if.max_ms = q.max_ms;
   assign reg_rdata = q.rdata;
   assign stage_enable = q.o_stage;
   assign torque_enable = q.o_torque;
   assign run_cw = q.o_cw;
   assign run_acw = q.o_acw;
   assign ramp_stop = q.o_ramp;
   assign emergency_stop = q.o_emer;
   assign dc_brake = q.o_dcb;
   assign flux_active = fx_if.active;
   assign magnetizing_current = q.o_mag;
   assign brake_current = q.o_brk;

   a_time_ranges: assert property (@(posedge clk_sys) disable iff (reset)
      q.min_ms <= fss_pkg::T_LIMIT && q.max_ms >= fss_pkg::T_ONE &&
      q.max_ms <= fss_pkg::T_LIMIT) else $error("time out of range");
   a_max_range: assert property (@(posedge clk_sys) disable iff (reset)
      (reg_wr && reg_addr == fss_pkg::OFS_MAX_TIME && reg_wdata == '0)
      |=> $stable(q.max_ms)) else $error("zero maximum accepted");
   a_no_torque_rest: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == fss_pkg::ST_IDLE) |=> !torque_enable)
      else $error("torque without flux phase");
   a_stop_on_pair: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == fss_pkg::ST_RUN && !one) |=> !run_cw && !run_acw)
      else $error("no stop on start pair");
   a_both_high_tens: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == fss_pkg::ST_RUN && both) |=>
      q.beh == eff_beh(tens_digit($past(q.stop_mode)), $past(q.cfg)))
      else $error("wrong digit for both high");
   a_stop_legal: assert property (@(posedge clk_sys) disable iff (reset)
      stop_ok(q.stop_mode)) else $error("illegal stop mode held");
   a_default_src: assert property (@(posedge clk_sys)
      $fell(reset) |-> q.src_cw == fss_pkg::SRC_CW_RST &&
      q.src_acw == fss_pkg::SRC_ACW_RST)
      else $error("wrong default start source");
   a_coast_off: assert property (@(posedge clk_sys) disable iff (reset)
      (stop_req && sel_beh == fss_pkg::BEH_COAST) |=>
      !stage_enable && magnetizing_current == '0)
      else $error("coast kept stage on");
   a_brake_start: assert property (@(posedge clk_sys) disable iff (reset)
      (stop_req && sel_beh == fss_pkg::BEH_DC_BRAKE) |=>
      dc_brake && brake_current == q.brk_cur &&
      $past(q.cfg) == fss_pkg::CFG_VF)
      else $error("dc brake not started");
   a_single_run: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == fss_pkg::ST_RUN && one) |=>
      run_cw == $past(cw) && run_acw == !$past(cw) && !ramp_stop)
      else $error("single start not run");
   c_coast: cover property (@(posedge clk_sys) disable iff (reset)
      q.st == fss_pkg::ST_RUN ##1 q.st == fss_pkg::ST_IDLE);
   c_brake: cover property (@(posedge clk_sys) disable iff (reset)
      q.st == fss_pkg::ST_BRAKE ##1 q.st == fss_pkg::ST_IDLE);
   c_hold: cover property (@(posedge clk_sys) disable iff (reset)
      q.st == fss_pkg::ST_RAMP ##1 q.st == fss_pkg::ST_HOLD);
   c_flux_run: cover property (@(posedge clk_sys) disable iff (reset)
      q.st == fss_pkg::ST_FLUX ##1 q.st == fss_pkg::ST_RUN);
endmodule : fss_top
`default_nettype wire

// ### fss_pkg.sv
// constants, codes and types of the flux start and stop select block
package fss_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned MS_NS = 1000000;
   // least time per tick: round up
   localparam int unsigned CYC_PER_MS =
      (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W = 18;
   // widths
   localparam int unsigned AW = 8;
   localparam int unsigned DW = 16;
   localparam int unsigned TW = 14;
   localparam int unsigned NUM_DI = 6;
   localparam int unsigned NUM_LS = 4;
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_MIN_TIME = 8'h04;
   localparam logic [7:0] OFS_MAX_TIME = 8'h08;
   localparam logic [7:0] OFS_STOP_MODE = 8'h0C;
   localparam logic [7:0] OFS_SRC_CW = 8'h10;
   localparam logic [7:0] OFS_SRC_ACW = 8'h14;
   localparam logic [7:0] OFS_FLUX_CUR = 8'h18;
   localparam logic [7:0] OFS_BRK_CUR = 8'h1C;
   localparam logic [7:0] OFS_BRK_TIME = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   // status field positions
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_FLUX_BIT = 3;
   localparam int unsigned ST_CW_BIT = 4;
   localparam int unsigned ST_ACW_BIT = 5;
   localparam int unsigned ST_STILL_BIT = 6;
   // control configurations
   localparam logic [9:0] CFG_VF = 10'h06E;
   localparam logic [9:0] CFG_ASYN = 10'h19A;
   localparam logic [9:0] CFG_SYN = 10'h262;
   // flux-formation time limits and defaults in ms
   localparam logic [13:0] T_LIMIT = 14'h2710;
   localparam logic [13:0] T_ONE = 14'h0001;
   localparam logic [13:0] MIN_DEF_ASYN = 14'h000A;
   localparam logic [13:0] MIN_DEF_SYN = 14'h0032;
   localparam logic [13:0] MAX_DEF_VF = 14'h012C;
   localparam logic [13:0] MAX_DEF_ASYN = 14'h03E8;
   localparam logic [13:0] MAX_DEF_SYN = 14'h0032;
   // stop behaviour codes, one decimal digit each
   localparam logic [3:0] BEH_COAST = 4'h0;
   localparam logic [3:0] BEH_RAMP_OFF = 4'h1;
   localparam logic [3:0] BEH_RAMP_HOLD = 4'h2;
   localparam logic [3:0] BEH_EMER_OFF = 4'h4;
   localparam logic [3:0] BEH_EMER_HOLD = 4'h5;
   localparam logic [3:0] BEH_DC_BRAKE = 4'h7;
   localparam logic [6:0] STOP_MAX = 7'h4D;
   localparam logic [6:0] STOP_TEN = 7'h0A;
   // start source codes
   localparam logic [6:0] SRC_LOW = 7'h00;
   localparam logic [6:0] SRC_HIGH = 7'h01;
   localparam logic [6:0] SRC_DI_BASE = 7'h47;
   localparam logic [6:0] SRC_LS_BASE = 7'h50;
   // reset values
   localparam logic [6:0] STOP_RST = 7'h0B;
   localparam logic [6:0] SRC_CW_RST = 7'h47;
   localparam logic [6:0] SRC_ACW_RST = 7'h48;
   localparam logic [15:0] FLUX_CUR_RST = 16'h0100;
   localparam logic [15:0] BRK_CUR_RST = 16'h0100;
   localparam logic [13:0] BRK_TIME_RST = 14'h000A;

   typedef enum logic [2:0] {
      ST_IDLE, ST_FLUX, ST_RUN, ST_RAMP, ST_HOLD, ST_BRAKE
   } fss_state_t;
endpackage : fss_pkg

// ### fss_flux_if.sv
// signals between the main block and the flux-formation sequencer
`timescale 1ns/100ps
`default_nettype none
interface fss_flux_if;
   logic start;
   logic abort;
   logic ref_reached;
   logic ms_tick;
   logic [fss_pkg::TW-1:0] min_ms;
   logic [fss_pkg::TW-1:0] max_ms;
   logic active;
   logic done;
   modport ctl (
      output start, abort, ref_reached, ms_tick, min_ms, max_ms,
      input active, done
   );
   modport seq (
      input start, abort, ref_reached, ms_tick, min_ms, max_ms,
      output active, done
   );
endinterface : fss_flux_if
`default_nettype wire

// ### fss_flux_seq.sv
// flux-formation timer: ends the magnetizing phase by min/max time and flux
`timescale 1ns/100ps
`default_nettype none
module fss_flux_seq (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // control link
   fss_flux_if.seq fx
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [fss_pkg::TW-1:0] elapsed;
   } fss_flux_t;

   fss_flux_t q;
   fss_flux_t n;
   logic at_min;
   logic at_max;

   always_comb begin
      n = q;
      n.done = 1'b0;
      at_min = (q.elapsed >= fx.min_ms);
      at_max = (q.elapsed >= fx.max_ms);
      if (fx.abort) begin
         n.busy = 1'b0;
      end else if (fx.start) begin
         n.busy = 1'b1;
         n.elapsed = '0;
      end else if (q.busy) begin
         if (at_max || (at_min && fx.ref_reached)) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end else if (fx.ms_tick) begin
            n.elapsed = q.elapsed + 14'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign fx.active = q.busy;
   assign fx.done = q.done;

   a_zero_min_end: assert property (@(posedge clk_sys) disable iff (reset)
      (q.busy && !fx.abort && !fx.start && fx.min_ms == '0 && fx.ref_reached)
      |=> (q.done && !q.busy)) else $error("flux not ended at reference");
   a_min_time_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (q.busy && !fx.abort && q.elapsed < fx.min_ms && q.elapsed < fx.max_ms)
      |=> q.busy) else $error("flux ended before minimum time");
   a_equal_time_end: assert property (@(posedge clk_sys) disable iff (reset)
      (q.busy && !fx.abort && fx.min_ms == fx.max_ms && q.elapsed < fx.max_ms)
      |=> q.busy) else $error("flux ended early with equal times");
   a_max_time_end: assert property (@(posedge clk_sys) disable iff (reset)
      (q.busy && !fx.abort && !fx.start && q.elapsed >= fx.max_ms)
      |=> (q.done ##1 !q.done)) else $error("flux outlived maximum time");
   c_flux_by_ref: cover property (@(posedge clk_sys) disable iff (reset)
      q.busy && fx.ref_reached && q.elapsed < fx.max_ms ##1 q.done);
endmodule : fss_flux_seq
`default_nettype wire

// ### fss_motor.sv
// motor model: flux builds under current, a ramp ends in standstill
`timescale 1ns/100ps
`default_nettype none
module fss_motor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // drive side
   input wire logic [15:0] magnetizing_current,
   input wire logic ramp_stop,
   input wire logic stage_enable,
   input wire logic [15:0] ref_dly,
   // feedback
   output logic flux_ref_reached,
   output logic standstill
);
   int flux_n;
   int stop_n;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flux_n <= 0;
         stop_n <= 0;
      end else begin
         flux_n <= (magnetizing_current != 16'h0000) ? flux_n + 1 : 0;
         stop_n <= ramp_stop ? stop_n + 1 : (stage_enable ? stop_n : 0);
      end
   end
   assign flux_ref_reached = flux_n != 0 && flux_n >= int'(ref_dly);
   assign standstill = stop_n >= 20;
endmodule : fss_motor
`default_nettype wire

// ### tb_top.sv
// self-checking bench of the flux start and stop select block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int C = 10;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [5:0] digital_in = 6'h00;
   logic [3:0] logic_sig = 4'h0;
   logic [15:0] ref_dly = 16'h0005;
   logic [15:0] reg_rdata, magnetizing_current, brake_current;
   logic flux_ref_reached, standstill, stage_enable, torque_enable, run_cw;
   logic run_acw, ramp_stop, emergency_stop, dc_brake, flux_active;
   logic [31:0] rng = 32'h000147B7;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   fss_top #(.CYC_PER_MS(C)) dut (.clk_sys, .reset, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .digital_in, .logic_sig,
      .flux_ref_reached, .standstill, .stage_enable, .torque_enable,
      .run_cw, .run_acw, .ramp_stop, .emergency_stop, .dc_brake,
      .flux_active, .magnetizing_current, .brake_current);
   fss_motor motor (.clk_sys, .reset, .magnetizing_current, .ramp_stop,
      .stage_enable, .ref_dly, .flux_ref_reached, .standstill);
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input int d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= 16'(d);
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input int e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 16'(e));
   endtask : rd
   task automatic rst();
      @(posedge clk_sys);
      reset <= 1'b1;
      digital_in <= 6'h00;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
   endtask : rst
   task automatic upto(input bit tq, output int m);
      m = 0;
      do begin
         @(posedge clk_sys);
         #1 m++;
      end while ((tq ? torque_enable : stage_enable) !== 1'b1 && m < 2000);
   endtask : upto
   initial begin
      int c, e, m, r, k;
      int cd[6] = '{0, 1, 2, 4, 5, 7};
      int ft[4][3] = '{'{0, 5, 0}, '{3, 6, 5}, '{4, 4, 5}, '{2, 3, 999}};
      rst();
      rd(8'h00, 410);
      rd(8'h04, 10);
      rd(8'h08, 1000);
      rd(8'h0C, 11);
      rd(8'h10, 71);
      rd(8'h14, 72);
      rd(8'h30, 0);
      wr(8'h00, 110);
      rd(8'h08, 300);
      wr(8'h00, 610);
      rd(8'h04, 50);
      rd(8'h08, 50);
      wr(8'h08, 0);
      rd(8'h08, 50);
      wr(8'h0C, 13);
      rd(8'h0C, 11);
      // flux length against min, max and flux
      foreach (ft[i]) begin
         rng = xs(rng);
         r = (i == 0) ? 5 + int'(rng[3:0]) : ft[i][2];
         rst();
         wr(8'h04, ft[i][0]);
         wr(8'h08, ft[i][1]);
         ref_dly <= 16'(r);
         logic_sig <= rng[7:4];
         digital_in <= 6'h01;
         upto(1'b0, m);
         chk(magnetizing_current, 16'h0100);
         chk(16'(flux_active), 16'h0001);
         upto(1'b1, m);
         e = ft[i][1] * C;
         if (ft[i][0] != ft[i][1] && r < e)
            e = (r > ft[i][0] * C) ? r : ft[i][0] * C;
         chk(16'(m >= e && m <= e + C + 6), 16'h0001);
         chk(16'({flux_active, run_cw, run_acw}), 16'h0002);
      end
      // every code under both digits, 7 outside v/f
      for (int i = 0; i < 13; i++) begin
         c = (i == 12) ? 7 : cd[i % 6];
         k = (i == 12) ? 0 : c;
         rst();
         wr(8'h00, (i == 12) ? 410 : 110);
         wr(8'h04, 0);
         wr(8'h08, 2);
         wr(8'h0C, i < 6 ? c * 10 : c);
         digital_in <= (i % 2) ? 6'h02 : 6'h01;
         upto(1'b1, m);
         chk(16'({run_cw, run_acw}), (i % 2) ? 16'h0001 : 16'h0002);
         rd(8'h24, (i % 2) ? 16'h0022 : 16'h0012);
         @(posedge clk_sys);
         digital_in <= (i < 6) ? 6'h03 : 6'h00;
         repeat (6) @(posedge clk_sys);
         #1 chk(16'({stage_enable, ramp_stop, emergency_stop, dc_brake}),
            16'({k != 0, k == 1 || k == 2 || k > 3 && k < 6,
            k == 4 || k == 5, k == 7}));
         chk(brake_current, (k == 7) ? 16'h0100 : 16'h0000);
         // at standstill hold keeps current, switch-off disables
         repeat (30) @(posedge clk_sys);
         #1 chk(16'({stage_enable, torque_enable, ramp_stop}),
            16'({k == 2 || k == 5 || k == 7, k == 2 || k == 5, 1'b0}));
      end
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
